// ==== flrw_defines.vh ====
/*
 * Constants shared by the row latch writer and its latch store.
 * Assumes it is included by bare name from both design files.
 */
// Contract
// - Row from upper ten bits, latch from low five.
// - Programming stays inside the selected row.
// - Latches return blank after each programming.
// - Latches blank after erase; unloaded latches program blank.
// - Programming never erases anything by itself.
// - Thirty-two latches; one program writes whole row.
// - Accepted load copies data pair into latch.
// - Load-only flag set: only load the latch.
// - Flag clear: load latch, then program row.
// - Nothing happens unless unlock sequence completes.
// - Protected address: clear write start, skip program or erase; load-only loads still go.
// - Completion sets done flag and gated interrupt.
`ifndef FLRW_DEFINES_VH
`define FLRW_DEFINES_VH
`define FLRW_KEY_FIRST 8'h55
`define FLRW_KEY_SECOND 8'haa
`define FLRW_BLANK_WORD 14'h3fff
`define FLRW_WORD_W 14
`define FLRW_LATCH_COUNT 32
`define FLRW_IDX_W 5
`define FLRW_ROW_W 10
`define FLRW_ADDR_W 15
`define FLRW_ROW_LOW_MSB 7
`define FLRW_ROW_LOW_LSB 5
`define FLRW_IDX_MSB 4
`define FLRW_HIGH_MSB 6
`define FLRW_LAST_CNT 6'h21
`define FLRW_READ_END 6'h20
`endif

// ==== flrw_latch_mem.v ====
/*
 * Thirty-two word write latch store with registered read data.
 * Assumes one writer and a blank-all strobe from the sequencer.
 */
`include "flrw_defines.vh"
module flrw_latch_mem (
    // Clock and reset
    input wire mclk,
    input wire arst_n,
    // Write side
    input wire wr_en,
    input wire [`FLRW_IDX_W-1:0] wr_idx,
    input wire [`FLRW_WORD_W-1:0] wr_data,
    input wire blank_all,
    // Read side
    input wire [`FLRW_IDX_W-1:0] rd_idx,
    output reg [`FLRW_WORD_W-1:0] rd_data
);
    wire [`FLRW_LATCH_COUNT*`FLRW_WORD_W-1:0] words_flat;

    genvar g;
    generate
        for (g = 0; g < `FLRW_LATCH_COUNT; g = g + 1) begin : g_latch
            reg [`FLRW_WORD_W-1:0] word_reg;
            always @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    word_reg <= `FLRW_BLANK_WORD;
                end else if (blank_all) begin
                    word_reg <= `FLRW_BLANK_WORD;
                end else if (wr_en && wr_idx == g) begin
                    word_reg <= wr_data;
                end
            end
            assign words_flat[g*`FLRW_WORD_W +: `FLRW_WORD_W] = word_reg;
        end
    endgenerate

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= `FLRW_BLANK_WORD;
        end else begin
            rd_data <= words_flat[rd_idx*`FLRW_WORD_W +: `FLRW_WORD_W];
        end
    end
endmodule // flrw_latch_mem

// ==== flrw_top.v ====
/*
 * Self-programming write path: unlock sequence, write latch loading,
 * row programming and row erase toward the flash array.
 * Assumes software strobes come from logic on mclk, and the flash array
 * accepts one programmed word or one row erase per cycle.
 */
`include "flrw_defines.vh"
module flrw_top (
    // Clock and reset
    input wire mclk,
    input wire arst_n,
    // Address and data pair
    input wire [`FLRW_HIGH_MSB:0] flash_addr_high,
    input wire [7:0] flash_addr_low,
    input wire [5:0] flash_word_high,
    input wire [7:0] flash_word_low,
    // Control bits
    input wire write_permit,
    input wire config_space_select,
    input wire latch_load_only,
    input wire row_erase_select,
    input wire flash_done_irq_enable,
    input wire write_protect,
    // Unlock and start strobes
    input wire key_write,
    input wire [7:0] key_data,
    input wire unlock_abort,
    input wire write_start_set,
    // Flag clears
    input wire done_flag_clear,
    input wire write_error_clear,
    // Status
    output reg write_start,
    output reg flash_done_flag,
    output reg flash_done_irq,
    output reg write_error,
    // Flash array side
    output reg flash_prog_en,
    output reg [`FLRW_ADDR_W-1:0] flash_prog_addr,
    output reg [`FLRW_WORD_W-1:0] flash_prog_data,
    output reg flash_prog_space,
    output reg flash_erase_en,
    output reg [`FLRW_ROW_W-1:0] flash_erase_row
);
    localparam SEQ_IDLE = 3'b001;
    localparam SEQ_KEY1 = 3'b010;
    localparam SEQ_KEY2 = 3'b100;

    localparam OP_IDLE = 5'b00001;
    localparam OP_LOAD = 5'b00010;
    localparam OP_PROG = 5'b00100;
    localparam OP_ERASE = 5'b01000;
    localparam OP_DONE = 5'b10000;

    reg [2:0] seq_reg;
    reg [2:0] seq_next;
    reg [4:0] op_reg;
    reg [`FLRW_ROW_W-1:0] row_reg;
    reg [`FLRW_IDX_W-1:0] idx_reg;
    reg [`FLRW_WORD_W-1:0] data_reg;
    reg load_only_reg;
    reg erase_reg;
    reg blank_reg;
    reg [5:0] cnt_reg;
    reg rd_pend_reg;
    reg [`FLRW_IDX_W-1:0] pend_idx_reg;

    wire [`FLRW_ROW_W-1:0] sel_row;
    wire [`FLRW_IDX_W-1:0] sel_idx;
    wire [`FLRW_IDX_W-1:0] rd_idx;
    wire [`FLRW_WORD_W-1:0] rd_data;
    wire op_idle;
    wire accept;
    wire seq_break;
    wire protect_hit;
    wire done_event;
    wire error_event;

    // Row from the upper ten address bits, latch index from the low five.
    assign sel_row = {flash_addr_high,
        flash_addr_low[`FLRW_ROW_LOW_MSB:`FLRW_ROW_LOW_LSB]};
    assign sel_idx = flash_addr_low[`FLRW_IDX_MSB:0];
    assign op_idle = op_reg[0];

    // A start strobe counts only right after both keys, in order.
    assign accept = write_start_set && seq_reg == SEQ_KEY2 &&
        write_permit && op_idle;
    // Latch loads touch no memory, so protection only stops programming
    // and erasing.
    assign protect_hit = accept && write_protect &&
        (row_erase_select || !latch_load_only);
    assign seq_break = (seq_reg != SEQ_IDLE) && (unlock_abort ||
        (write_start_set && seq_reg != SEQ_KEY2) ||
        (key_write && seq_reg == SEQ_KEY2));
    assign error_event = protect_hit || seq_break ||
        (key_write && seq_reg == SEQ_KEY1 &&
         key_data != `FLRW_KEY_SECOND);
    assign done_event = op_reg == OP_DONE;

    always @* begin
        seq_next = seq_reg;
        if (unlock_abort) begin
            seq_next = SEQ_IDLE;
        end else if (write_start_set) begin
            seq_next = SEQ_IDLE;
        end else if (key_write) begin
            if (key_data == `FLRW_KEY_FIRST && seq_reg != SEQ_KEY1) begin
                seq_next = SEQ_KEY1;
            end else if (key_data == `FLRW_KEY_SECOND &&
                         seq_reg == SEQ_KEY1) begin
                seq_next = SEQ_KEY2;
            end else begin
                seq_next = SEQ_IDLE;
            end
        end
    end

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            seq_reg <= SEQ_IDLE;
        end else begin
            seq_reg <= seq_next;
        end
    end

    // The programming walk reads latch k while latch k-2 leaves the chip.
    assign rd_idx = cnt_reg[`FLRW_IDX_W-1:0];

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            op_reg <= OP_IDLE;
            row_reg <= {`FLRW_ROW_W{1'b0}};
            idx_reg <= {`FLRW_IDX_W{1'b0}};
            data_reg <= `FLRW_BLANK_WORD;
            load_only_reg <= 1'b0;
            erase_reg <= 1'b0;
            blank_reg <= 1'b0;
            cnt_reg <= 6'h00;
            rd_pend_reg <= 1'b0;
            pend_idx_reg <= {`FLRW_IDX_W{1'b0}};
            write_start <= 1'b0;
            flash_prog_space <= 1'b0;
        end else begin
            blank_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            case (op_reg)
                OP_IDLE: begin
                    if (accept && !protect_hit) begin
                        write_start <= 1'b1;
                        row_reg <= sel_row;
                        idx_reg <= sel_idx;
                        data_reg <= {flash_word_high, flash_word_low};
                        load_only_reg <= latch_load_only;
                        erase_reg <= row_erase_select;
                        flash_prog_space <= config_space_select;
                        cnt_reg <= 6'h00;
                        if (row_erase_select) begin
                            op_reg <= OP_ERASE;
                        end else begin
                            op_reg <= OP_LOAD;
                        end
                    end
                end
                OP_LOAD: begin
                    if (load_only_reg) begin
                        op_reg <= OP_DONE;
                    end else begin
                        op_reg <= OP_PROG;
                    end
                end
                OP_PROG: begin
                    cnt_reg <= cnt_reg + 6'h01;
                    rd_pend_reg <= cnt_reg < `FLRW_READ_END;
                    pend_idx_reg <= rd_idx;
                    if (cnt_reg == `FLRW_LAST_CNT) begin
                        op_reg <= OP_DONE;
                        blank_reg <= 1'b1;
                    end
                end
                OP_ERASE: begin
                    op_reg <= OP_DONE;
                    blank_reg <= 1'b1;
                end
                OP_DONE: begin
                    write_start <= 1'b0;
                    op_reg <= OP_IDLE;
                end
                default: begin
                    op_reg <= OP_IDLE;
                end
            endcase
        end
    end

    flrw_latch_mem u_latches (
        .mclk(mclk),
        .arst_n(arst_n),
        .wr_en(op_reg == OP_LOAD),
        .wr_idx(idx_reg),
        .wr_data(data_reg),
        .blank_all(blank_reg),
        .rd_idx(rd_idx),
        .rd_data(rd_data)
    );

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            flash_prog_en <= 1'b0;
            flash_prog_addr <= {`FLRW_ADDR_W{1'b0}};
            flash_prog_data <= `FLRW_BLANK_WORD;
            flash_erase_en <= 1'b0;
            flash_erase_row <= {`FLRW_ROW_W{1'b0}};
        end else begin
            flash_prog_en <= rd_pend_reg;
            // The row part is frozen at start, so the walk cannot wrap
            // into the next row.
            flash_prog_addr <= {row_reg, pend_idx_reg};
            flash_prog_data <= rd_data;
            flash_erase_en <= op_reg == OP_ERASE && erase_reg;
            flash_erase_row <= row_reg;
        end
    end

    // Set wins over a clear arriving in the same cycle.
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            flash_done_flag <= 1'b0;
            flash_done_irq <= 1'b0;
            write_error <= 1'b0;
        end else begin
            if (done_event) begin
                flash_done_flag <= 1'b1;
            end else if (done_flag_clear) begin
                flash_done_flag <= 1'b0;
            end
            flash_done_irq <= flash_done_irq_enable &&
                (done_event || (flash_done_flag && !done_flag_clear));
            if (error_event) begin
                write_error <= 1'b1;
            end else if (write_error_clear) begin
                write_error <= 1'b0;
            end
        end
    end
endmodule // flrw_top

// ==== flrw_top_assertions.sv ====
/*
 * Port-level checker for the row latch writer.
 * Assumes it is bound to flrw_top and sees only that module's ports.
 */
module flrw_chk (
    // Clock and reset
    input wire mclk,
    input wire arst_n,
    // Inputs watched
    input wire [6:0] flash_addr_high,
    input wire [7:0] flash_addr_low,
    input wire latch_load_only,
    input wire row_erase_select,
    input wire write_permit,
    input wire write_protect,
    input wire write_start_set,
    input wire flash_done_irq_enable,
    // Outputs watched
    input wire write_start,
    input wire flash_done_flag,
    input wire flash_done_irq,
    input wire flash_prog_en,
    input wire [14:0] flash_prog_addr,
    input wire flash_erase_en,
    input wire [9:0] flash_erase_row
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    property p_erase_one; flash_erase_en |=> !flash_erase_en; endproperty
    a_erase_one: assert property (p_erase_one) else $error("erase");
    property p_erase_row;
        flash_erase_en |->
            flash_erase_row == {flash_addr_high, flash_addr_low[7:5]};
    endproperty
    a_erase_row: assert property (p_erase_row) else $error("erow");
    // Word pulses run back to back, so neighbours share one row.
    property p_row_fixed; flash_prog_en && $past(flash_prog_en) |->
        flash_prog_addr[14:5] == $past(flash_prog_addr[14:5]); endproperty
    a_row_fixed: assert property (p_row_fixed) else $error("row");
    property p_idx_step; flash_prog_en && $past(flash_prog_en) |->
        flash_prog_addr[4:0] == $past(flash_prog_addr[4:0]) + 5'h1; endproperty
    a_idx_step: assert property (p_idx_step) else $error("index step");
    property p_prog_busy; flash_prog_en |-> write_start; endproperty
    a_prog_busy: assert property (p_prog_busy) else $error("prog");
    property p_start_cause; $rose(write_start) |->
        $past(write_start_set) && $past(write_permit); endproperty
    a_start_cause: assert property (p_start_cause)
        else $error("start");
    property p_load_only;
        $rose(write_start) && $past(latch_load_only) &&
            !$past(row_erase_select) |->
            (!flash_prog_en && !flash_erase_en)[*2] ##1 !write_start;
    endproperty
    a_load_only: assert property (p_load_only) else $error("load");
    property p_prot; write_start_set && write_protect && !latch_load_only &&
        !write_start |=> !write_start ##1 !write_start; endproperty
    a_prot: assert property (p_prot) else $error("protected start");
    property p_done; $fell(write_start) |-> flash_done_flag; endproperty
    a_done: assert property (p_done) else $error("done flag");
    // Two quiet cycles allow for the registered interrupt output.
    property p_irq; !flash_done_irq_enable && !$past(flash_done_irq_enable)
        |-> !flash_done_irq; endproperty
    a_irq: assert property (p_irq) else $error("irq gate");
endmodule // flrw_chk

bind flrw_top flrw_chk u_chk (.mclk, .arst_n, .flash_addr_high,
    .flash_addr_low, .latch_load_only, .row_erase_select, .write_permit,
    .write_protect, .write_start_set, .flash_done_irq_enable, .write_start,
    .flash_done_flag, .flash_done_irq, .flash_prog_en, .flash_prog_addr,
    .flash_erase_en, .flash_erase_row);

// ==== tb_flrw_top.sv ====
/*
 * Self-checking bench for flrw_top with a latch model in integers.
 * Assumes the checker is bound in and inputs change at falling edges.
 */
module tb_flrw_top;
    timeunit 1ns;
    timeprecision 1ps;
    reg mclk = 1'b0;
    reg arst_n = 1'b0;
    reg [6:0] flash_addr_high = 7'h00;
    reg [7:0] flash_addr_low = 8'h00;
    reg [5:0] flash_word_high = 6'h00;
    reg [7:0] flash_word_low = 8'h00;
    reg write_permit = 1'b1, config_space_select = 1'b0;
    reg latch_load_only = 1'b1, row_erase_select = 1'b0;
    reg flash_done_irq_enable = 1'b1, write_protect = 1'b0;
    reg key_write = 1'b0, unlock_abort = 1'b0, write_start_set = 1'b0;
    reg [7:0] key_data = 8'h00;
    reg done_flag_clear = 1'b0, write_error_clear = 1'b0;
    reg [31:0] r;
    wire write_start, flash_done_flag, flash_done_irq, write_error;
    wire flash_prog_en, flash_prog_space, flash_erase_en;
    wire [14:0] flash_prog_addr;
    wire [13:0] flash_prog_data;
    wire [9:0] flash_erase_row;
    integer fail_count = 0, comparisons = 0, seed = 20, cycles = 0;
    integer lat [0:31];
    integer words, erases, i;
    flrw_top u_dut (.mclk, .arst_n, .flash_addr_high, .flash_addr_low,
        .flash_word_high, .flash_word_low, .write_permit,
        .config_space_select, .latch_load_only, .row_erase_select,
        .flash_done_irq_enable, .write_protect, .key_write, .key_data,
        .unlock_abort, .write_start_set, .done_flag_clear,
        .write_error_clear, .write_start, .flash_done_flag, .flash_done_irq,
        .write_error, .flash_prog_en, .flash_prog_addr, .flash_prog_data,
        .flash_prog_space, .flash_erase_en, .flash_erase_row);
    always #20 mclk = ~mclk;
    task give_verdict;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            fail_count = fail_count + 1;
            give_verdict;
        end
    end
    task check(input string what, input [15:0] exp, input [15:0] got);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task key(input [7:0] v);
        @(negedge mclk);
        key_write = 1'b1;
        key_data = v;
        @(negedge mclk);
        key_write = 1'b0;
    endtask
    // Runs one unlock sequence and records every word and erase it causes.
    task op(input abort);
        key(8'h55);
        key(8'haa);
        @(negedge mclk);
        if (abort) unlock_abort = 1'b1;
        else write_start_set = 1'b1;
        @(negedge mclk);
        unlock_abort = 1'b0;
        write_start_set = 1'b0;
        words = 0;
        erases = 0;
        repeat (45) begin
            @(negedge mclk);
            if (flash_prog_en === 1'b1) begin
                check("addr", {flash_addr_high, flash_addr_low[7:5],
                    words[4:0]}, flash_prog_addr);
                check("data", lat[words], flash_prog_data);
                check("space", config_space_select,
                    flash_prog_space);
                words = words + 1;
            end
            if (flash_erase_en === 1'b1) begin
                check("erow", {flash_addr_high, flash_addr_low[7:5]},
                    flash_erase_row);
                erases = erases + 1;
            end
        end
    endtask
    task load(input [4:0] idx, input [13:0] d, input take, input abort);
        @(negedge mclk);
        flash_addr_low[4:0] = idx;
        {flash_word_high, flash_word_low} = d;
        if (take) lat[idx] = d;
        op(abort);
    endtask
    task flags(input [2:0] e);
        check("flags", e,
            {write_start, flash_done_flag, write_error});
        @(negedge mclk);
        done_flag_clear = 1'b1;
        write_error_clear = 1'b1;
        @(negedge mclk);
        done_flag_clear = 1'b0;
        write_error_clear = 1'b0;
    endtask
    task blank;
        for (i = 0; i < 32; i++) lat[i] = 16383;
    endtask
    initial begin
        blank;
        repeat (8) @(negedge mclk);
        arst_n = 1'b1;
        check("rst", 14'h3fff, flash_prog_data);
        r = $random(seed);
        {flash_addr_high, flash_addr_low[7:5]} = r[9:0];
        for (int n = 0; n < 6; n++) begin
            r = $random(seed);
            load(r[4:0], r[18:5], 1'b1, 1'b0);
            check("words", 0, words);
            check("irq", 1, flash_done_irq);
            flags(3'b010);
        end
        load(5'h02, 14'h0123, 1'b0, 1'b1);
        flags(3'b001);
        write_permit = 1'b0;
        load(5'h03, 14'h0456, 1'b0, 1'b0);
        write_permit = 1'b1;
        flags(3'b000);
        latch_load_only = 1'b0;
        r = $random(seed);
        load(5'h1f, r[13:0], 1'b1, 1'b0);
        check("words", 32, words);
        flags(3'b010);
        blank;
        // A second row shows every latch went blank after programming.
        // It has never been written, so it needs no erase first.
        flash_addr_high = ~flash_addr_high;
        load(5'h09, 14'h0abc, 1'b1, 1'b0);
        check("words", 32, words);
        flags(3'b010);
        blank;
        latch_load_only = 1'b1;
        load(5'h04, 14'h1234, 1'b1, 1'b0);
        flags(3'b010);
        row_erase_select = 1'b1;
        flash_done_irq_enable = 1'b0;
        op(1'b0);
        check("erases", 1, erases);
        check("irq", 0, flash_done_irq);
        flags(3'b010);
        blank;
        row_erase_select = 1'b0;
        flash_done_irq_enable = 1'b1;
        latch_load_only = 1'b0;
        load(5'h07, 14'h2222, 1'b1, 1'b0);
        check("words", 32, words);
        check("erases", 0, erases);
        flags(3'b010);
        blank;
        write_protect = 1'b1;
        load(5'h07, 14'h0777, 1'b0, 1'b0);
        check("words", 0, words);
        flags(3'b001);
        give_verdict;
    end
endmodule // tb_flrw_top
